// ==== hdl/psm_modbus_slave.sv ====
/*
 * serial slave register logic: status word, setup word, on/off command,
 * voltage reading, read/write frame handling with crc16.
 * assumes a uart front end on clk_sys delivering bytes and a frame-gap pulse.
 */
`timescale 1ns/1ps
module psm_modbus_slave #(
  parameter int MS_TICK  = psm_pkg::MS_CYCLES,
  parameter int SHORT_MS = psm_pkg::DELAY_SHORT_MS,
  parameter int LONG_MS  = psm_pkg::DELAY_LONG_MS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  slaveAddr,
  input  wire logic        outputGoodFlag,
  input  wire logic        dummyLoadActive,
  input  wire logic        initDone,
  input  wire logic        nvmAccessError,
  input  wire logic        remoteOn,
  input  wire logic        savedOnOff,
  input  wire logic [15:0] outputVoltageReading,
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxValid,
  input  wire logic        rxFrameEnd,
  input  wire logic        txReady,
  output logic [7:0]       txByte,
  output logic             txValid,
  output logic             outputEnable,
  output logic             outputOnCommand,
  output logic             serialControlSelect,
  output logic [1:0]       nvmWritePolicy,
  output logic             nvmStoreDisable,
  output logic             nvmStorePulse
);
  import psm_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [13:0] sync1_q;
  logic [13:0] sync2_q;
  logic [7:0]  addrS;
  logic        goodS;
  logic        dloadS;
  logic        initS;
  logic        nvmErrS;
  logic        remoteS;
  logic        savedS;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 14'h0000;
      sync2_q <= 14'h0000;
    end else begin
      sync1_q <= {slaveAddr, outputGoodFlag, dummyLoadActive, initDone,
                  nvmAccessError, remoteOn, savedOnOff};
      sync2_q <= sync1_q;
    end
  end

  assign {addrS, goodS, dloadS, initS, nvmErrS, remoteS, savedS} = sync2_q;

  // ************************************************************
  // register contents
  // ************************************************************
  logic [15:0] setup_q;
  logic [15:0] setup_d;
  logic        onOff_q;
  logic [1:0]  startCnt_q;
  logic        outEn_q;
  logic [15:0] statusWord;
  logic [7:0]  rxBuf_q [8];
  logic [15:0] reqStart;
  logic [15:0] reqCount;
  logic [7:0]  reqFc;
  logic        writeHit;
  logic        paramWrite;
  psm_state_e  state_q;

  always_comb begin
    statusWord = 16'h0000;
    statusWord[ST_GOOD_BIT] = goodS;
    statusWord[ST_DLOAD_BIT] = dloadS;
    statusWord[ST_INIT_BIT] = initS;
    statusWord[ST_NVMERR_BIT] = nvmErrS;
  end

  assign reqFc    = rxBuf_q[1];
  assign reqStart = {rxBuf_q[2], rxBuf_q[3]};
  assign reqCount = {rxBuf_q[4], rxBuf_q[5]};
  assign writeHit = (state_q == ST_EXEC) && (reqFc == FC_WRITE_ONE);
  assign paramWrite = writeHit && (reqStart == ADDR_ON_OFF || reqStart == ADDR_SETUP);

  // reserved codes keep the previous field so the word never holds them
  always_comb begin
    setup_d = setup_q;
    if (writeHit && reqStart == ADDR_SETUP) begin
      setup_d[CFG_SERIAL_BIT] = reqCount[CFG_SERIAL_BIT];
      if (reqCount[CFG_OPINIT_LSB+:2] != CODE_RSVD) begin
        setup_d[CFG_OPINIT_LSB+:2] = reqCount[CFG_OPINIT_LSB+:2];
      end
      if (reqCount[CFG_POLICY_LSB+:2] != CODE_RSVD) begin
        setup_d[CFG_POLICY_LSB+:2] = reqCount[CFG_POLICY_LSB+:2];
      end
      setup_d[CFG_NOSTORE_BIT] = reqCount[CFG_NOSTORE_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      setup_q <= SETUP_RESET;
    end else begin
      setup_q <= setup_d & SETUP_MASK;
    end
  end

  // power-up preset waits for the synchronisers to carry the saved level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      startCnt_q <= 2'b00;
      onOff_q    <= ON_OFF_RESET;
    end else if (startCnt_q != 2'b11) begin
      startCnt_q <= startCnt_q + 2'b01;
      if (startCnt_q == 2'b10) begin
        case (setup_q[CFG_OPINIT_LSB+:2])
          OPINIT_OFF:  onOff_q <= 1'b0;
          OPINIT_ON:   onOff_q <= 1'b1;
          OPINIT_PREV: onOff_q <= savedS;
          default:     onOff_q <= onOff_q;
        endcase
      end
    end else if (writeHit && reqStart == ADDR_ON_OFF) begin
      if (reqCount == CMD_ON || reqCount == CMD_OFF) begin
        onOff_q <= reqCount[0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      outEn_q <= 1'b0;
    end else begin
      outEn_q <= setup_q[CFG_SERIAL_BIT] ? onOff_q : remoteS;
    end
  end

  assign outputEnable        = outEn_q;
  assign outputOnCommand     = onOff_q;
  assign serialControlSelect = setup_q[CFG_SERIAL_BIT];
  assign nvmWritePolicy      = setup_q[CFG_POLICY_LSB+:2];
  assign nvmStoreDisable     = setup_q[CFG_NOSTORE_BIT];

  // ************************************************************
  // nonvolatile store scheduling
  // ************************************************************
  logic [31:0] msDiv_q;
  logic [19:0] delay_q;
  logic [19:0] delayLimit;
  logic        pending_q;
  logic        store_q;
  logic        msTick;

  assign msTick     = (msDiv_q == 32'(MS_TICK - 1));
  assign delayLimit = (nvmWritePolicy == POLICY_MIN1) ? 20'(SHORT_MS) : 20'(LONG_MS);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      msDiv_q <= 32'h0000_0000;
    end else if (msTick || paramWrite) begin
      msDiv_q <= 32'h0000_0000;
    end else begin
      msDiv_q <= msDiv_q + 32'h0000_0001;
    end
  end

  // each parameter write restarts the quiet-time wait
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pending_q <= 1'b0;
      delay_q   <= 20'h00000;
      store_q   <= 1'b0;
    end else begin
      store_q <= 1'b0;
      if (paramWrite && !nvmStoreDisable) begin
        if (nvmWritePolicy == POLICY_NOW) begin
          store_q   <= 1'b1;
          pending_q <= 1'b0;
        end else begin
          pending_q <= 1'b1;
          delay_q   <= 20'h00000;
        end
      end else if (pending_q && nvmStoreDisable) begin
        pending_q <= 1'b0;
      end else if (pending_q && msTick) begin
        if (delay_q + 20'h00001 >= delayLimit) begin
          store_q   <= 1'b1;
          pending_q <= 1'b0;
        end else begin
          delay_q <= delay_q + 20'h00001;
        end
      end
    end
  end

  assign nvmStorePulse = store_q;

  // ************************************************************
  // frame reception
  // ************************************************************
  logic [3:0]  rxCnt_q;
  logic [15:0] rxCrc_q;
  logic        fcOk;
  logic        frameOk;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxCnt_q <= 4'h0;
      rxCrc_q <= CRC_INIT;
      for (int i = 0; i < 8; i++) begin
        rxBuf_q[i] <= 8'h00;
      end
    end else if (rxFrameEnd) begin
      rxCnt_q <= 4'h0;
      rxCrc_q <= CRC_INIT;
    end else if (rxValid && state_q == ST_RX) begin
      if (rxCnt_q < REQ_LEN) begin
        rxBuf_q[rxCnt_q[2:0]] <= rxByte;
      end
      if (rxCnt_q != REQ_OVER) begin
        rxCnt_q <= rxCnt_q + 4'h1;
      end
      rxCrc_q <= crcStep(rxCrc_q, rxByte);
    end
  end

  assign fcOk = (reqFc == FC_WRITE_ONE) ||
                ((reqFc == FC_READ_HOLD || reqFc == FC_READ_INPUT) &&
                 reqCount != 16'h0000 && reqCount <= MAX_REGS);
  assign frameOk = (state_q == ST_RX) && rxFrameEnd && (rxCnt_q == REQ_LEN) &&
                   (rxCrc_q == 16'h0000) && (rxBuf_q[0] == addrS) && fcOk;

  // ************************************************************
  // answer generation
  // ************************************************************
  logic [7:0]  txIdx_q;
  logic [7:0]  txLen_q;
  logic [15:0] txCrc_q;
  logic [15:0] txResid_q;
  logic        isEcho_q;
  logic [7:0]  txByte_q;
  logic        txValid_q;
  logic [7:0]  dataK;
  logic [15:0] regAddr;
  logic [15:0] regWord;
  logic [7:0]  txNext;
  logic        txLast;

  always_comb begin
    dataK   = txIdx_q - RSP_HDR;
    regAddr = reqStart + {9'h000, dataK[7:1]};
    regWord = 16'h0000;
    if (regAddr == ADDR_ON_OFF) begin
      regWord = {15'h0000, onOff_q};
    end else if (regAddr == ADDR_VOUT) begin
      regWord = outputVoltageReading;
    end else if (regAddr == ADDR_STATUS) begin
      regWord = statusWord;
    end else if (regAddr == ADDR_SETUP) begin
      regWord = setup_q;
    end
    if (isEcho_q) begin
      txNext = rxBuf_q[txIdx_q[2:0]];
    end else if (txIdx_q < 8'h02) begin
      txNext = rxBuf_q[txIdx_q[0]];
    end else if (txIdx_q == 8'h02) begin
      txNext = {reqCount[6:0], 1'b0};
    end else if (txIdx_q == txLen_q - 8'h02) begin
      txNext = txCrc_q[7:0];
    end else if (txIdx_q == txLen_q - 8'h01) begin
      txNext = txCrc_q[15:8];
    end else begin
      txNext = dataK[0] ? regWord[7:0] : regWord[15:8];
    end
  end

  assign txLast = (txIdx_q == txLen_q - 8'h01);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RX;
    end else begin
      case (state_q)
        ST_RX:   state_q <= frameOk ? ST_EXEC : ST_RX;
        ST_EXEC: state_q <= ST_LOAD;
        ST_LOAD: state_q <= ST_TX;
        default: begin
          if (txReady) begin
            state_q <= txLast ? ST_RX : ST_LOAD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txIdx_q   <= 8'h00;
      txLen_q   <= 8'h00;
      txCrc_q   <= CRC_INIT;
      txResid_q <= CRC_INIT;
      isEcho_q  <= 1'b0;
      txByte_q  <= 8'h00;
      txValid_q <= 1'b0;
    end else if (state_q == ST_EXEC) begin
      txIdx_q   <= 8'h00;
      txCrc_q   <= CRC_INIT;
      txResid_q <= CRC_INIT;
      isEcho_q  <= writeHit;
      txLen_q   <= writeHit ? {4'h0, REQ_LEN} : RSP_OVERHEAD + {reqCount[6:0], 1'b0};
    end else if (state_q == ST_LOAD) begin
      txByte_q  <= txNext;
      txValid_q <= 1'b1;
      // check bytes must not fold into the sum they carry, or the high byte goes wrong
      if (txIdx_q < txLen_q - 8'h02) begin
        txCrc_q <= crcStep(txCrc_q, txNext);
      end
    end else if (state_q == ST_TX && txReady) begin
      txValid_q <= 1'b0;
      txIdx_q   <= txIdx_q + 8'h01;
      txResid_q <= crcStep(txResid_q, txByte_q);
    end
  end

  assign txByte  = txByte_q;
  assign txValid = txValid_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_GOOD_BIT: assert property (statusWord[ST_GOOD_BIT] == $past(outputGoodFlag, 2))
    else $error("output good bit does not follow pin");
  AST_DLOAD_BIT: assert property (statusWord[ST_DLOAD_BIT] == $past(dummyLoadActive, 2))
    else $error("dummy load bit does not follow pin");
  AST_INIT_BIT: assert property (statusWord[ST_INIT_BIT] == $past(initDone, 2))
    else $error("init bit does not follow pin");
  AST_NVMERR_BIT: assert property (statusWord[ST_NVMERR_BIT] == $past(nvmAccessError, 2))
    else $error("nvm error bit does not follow pin");
  AST_UNUSED_ZERO: assert property (((statusWord & ~STATUS_MASK) == 16'h0000) &&
                                    ((setup_q & ~SETUP_MASK) == 16'h0000))
    else $error("unassigned bit reads one");
  AST_SERIAL_CTRL: assert property (serialControlSelect |=> outputEnable == $past(onOff_q))
    else $error("serial control not applied");
  AST_NO_RSVD: assert property (setup_q[CFG_OPINIT_LSB+:2] != CODE_RSVD && nvmWritePolicy != CODE_RSVD)
    else $error("reserved code stored");
  AST_STORE_NOW: assert property (paramWrite && nvmWritePolicy == POLICY_NOW && !nvmStoreDisable
                                  |=> nvmStorePulse)
    else $error("immediate store missing");
  AST_STORE_OFF: assert property (nvmStoreDisable && $past(nvmStoreDisable) |-> !nvmStorePulse)
    else $error("store while disabled");
  AST_BYTE_COUNT: assert property (txValid && !isEcho_q && txIdx_q == 8'h02
                                   |-> txByte == {reqCount[6:0], 1'b0})
    else $error("wrong byte count");
  AST_CRC_CLOSE: assert property (state_q == ST_TX && txReady && txLast |=> txResid_q == 16'h0000)
    else $error("answer crc does not close");
  AST_ECHO: assert property (txValid && isEcho_q |-> txByte == rxBuf_q[txIdx_q[2:0]])
    else $error("echo differs from request");
  AST_DISCARD: assert property (state_q == ST_RX && rxFrameEnd && rxCrc_q != 16'h0000 |=> state_q == ST_RX)
    else $error("bad crc frame answered");
  AST_ON_CMD: assert property (writeHit && reqStart == ADDR_ON_OFF && reqCount == CMD_ON
                               && startCnt_q == 2'b11 |=> onOff_q ##1 state_q == ST_TX)
    else $error("on command not taken");

  COV_READ: cover property (state_q == ST_EXEC && reqFc == FC_READ_INPUT);
  COV_ECHO: cover property (state_q == ST_TX && txLast && isEcho_q);
  COV_DELAYED: cover property (nvmStorePulse && nvmWritePolicy == POLICY_MIN1);
endmodule

// ==== hdl/psm_pkg.sv ====
/*
 * constants, field layout and state type of the power supply serial slave.
 * assumes one 100 MHz system clock and a byte-level serial front end.
 */
package psm_pkg;
  // ************************************************************
  // register map and function codes
  // ************************************************************
  localparam logic [15:0] ADDR_ON_OFF   = 16'h0000;
  localparam logic [15:0] ADDR_VOUT     = 16'h0060;
  localparam logic [15:0] ADDR_STATUS   = 16'h00c3;
  localparam logic [15:0] ADDR_SETUP    = 16'h00c4;
  localparam logic [7:0]  FC_READ_HOLD  = 8'h03;
  localparam logic [7:0]  FC_READ_INPUT = 8'h04;
  localparam logic [7:0]  FC_WRITE_ONE  = 8'h06;
  localparam logic [3:0]  REQ_LEN       = 4'h8;
  localparam logic [3:0]  REQ_OVER      = 4'h9;
  localparam logic [7:0]  RSP_HDR       = 8'h03;
  localparam logic [7:0]  RSP_OVERHEAD  = 8'h05;
  localparam logic [15:0] MAX_REGS      = 16'h007d;
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'ha001;
  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int          ST_GOOD_BIT    = 1;
  localparam int          ST_DLOAD_BIT   = 4;
  localparam int          ST_INIT_BIT    = 5;
  localparam int          ST_NVMERR_BIT  = 6;
  localparam logic [15:0] STATUS_MASK    = 16'h0072;
  localparam int          CFG_SERIAL_BIT = 0;
  localparam int          CFG_OPINIT_LSB = 1;
  localparam int          CFG_POLICY_LSB = 8;
  localparam int          CFG_NOSTORE_BIT = 10;
  localparam logic [15:0] SETUP_MASK     = 16'h0707;
  localparam logic [15:0] SETUP_RESET    = 16'h0002;
  localparam logic [15:0] CMD_ON         = 16'h0001;
  localparam logic [15:0] CMD_OFF        = 16'h0000;
  localparam logic        ON_OFF_RESET   = 1'b1;
  localparam logic [1:0]  OPINIT_OFF     = 2'b00;
  localparam logic [1:0]  OPINIT_ON      = 2'b01;
  localparam logic [1:0]  OPINIT_PREV    = 2'b10;
  localparam logic [1:0]  CODE_RSVD      = 2'b11;
  localparam logic [1:0]  POLICY_NOW     = 2'b00;
  localparam logic [1:0]  POLICY_MIN1    = 2'b01;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int MS_NS           = 1000000;
  localparam int MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_MIN      = 60000;
  localparam int DELAY_SHORT_MIN = 1;
  localparam int DELAY_LONG_MIN  = 10;
  localparam int DELAY_SHORT_MS  = DELAY_SHORT_MIN * MS_PER_MIN;
  localparam int DELAY_LONG_MS   = DELAY_LONG_MIN * MS_PER_MIN;

  typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_LOAD, ST_TX} psm_state_e;
endpackage

// ==== tb/psm_master_model.sv ====
/*
 * behavioural serial master facing the slave: sends whole request frames
 * byte by byte and accepts answer bytes with random stalls.
 * assumes the slave's byte-level front end on clk_sys, one byte per cycle.
 */
`timescale 1ns/1ps
module psm_master_model (
  input  wire logic clk_sys,
  output logic [7:0] rxByte,
  output logic       rxValid,
  output logic       rxFrameEnd,
  output logic       txReady
);
  int seed = 54;

  // ************************************************************
  // idle levels and answer acceptance
  // ************************************************************
  initial begin
    rxByte = 8'h00;
    rxValid = 1'b0;
    rxFrameEnd = 1'b0;
    txReady = 1'b0;
  end

  // random stalls, so the slave must hold each answer byte
  always @(posedge clk_sys) begin
    txReady <= 1'($random(seed));
  end

  // ************************************************************
  // frame check sum and request sender
  // ************************************************************
  function automatic logic [15:0] crc16(input logic [63:0] d, input int n);
    logic [15:0] c;
    c = psm_pkg::CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, d[63-8*i -: 8]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ psm_pkg::CRC_POLY) : (c >> 1);
      end
    end
    return c;
  endfunction

  // bad flips the low check sum bit so the slave must stay silent
  task automatic send(input logic [47:0] h, input logic bad);
    logic [15:0] c;
    logic [63:0] f;
    c = crc16({h, 16'h0000}, 6) ^ {15'h0000, bad};
    f = {h, c[7:0], c[15:8]};
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      rxByte <= f[63-8*i -: 8];
      rxValid <= 1'b1;
    end
    @(posedge clk_sys);
    rxValid <= 1'b0;
    // released line must not keep showing the last byte
    rxByte <= ~f[7:0];
    rxFrameEnd <= 1'b1;
    @(posedge clk_sys);
    rxFrameEnd <= 1'b0;
  endtask
endmodule

// ==== tb/psm_modbus_slave_tb.sv ====
/*
 * self-checking bench of the serial slave: reads, writes, refused frames.
 * assumes the master model in psm_master_model.sv and shortened ms timing.
 */
`timescale 1ns/1ps
module psm_modbus_slave_tb;
  import psm_pkg::*;
  localparam int TICK = 10;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] slaveAddr = 8'h80;
  logic [3:0] pins = 4'h0;
  logic remoteOn = 1'b1;
  logic [15:0] vout = 16'h0000;
  logic [7:0] rxByte, txByte;
  logic rxValid, rxFrameEnd, txReady, txValid, outputEnable, outputOnCommand;
  logic serialControlSelect, nvmStoreDisable, nvmStorePulse;
  logic [1:0] nvmWritePolicy;
  logic [7:0] q[$];
  logic [15:0] setup = 16'h0002;
  int err_count = 0;
  int checks_done = 0;
  int pulses = 0;
  int seed = 54;
  int base;

  always #5 clk_sys = ~clk_sys;

  psm_modbus_slave #(.MS_TICK(TICK), .SHORT_MS(3), .LONG_MS(5)) psm_modbus_slave_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .slaveAddr(slaveAddr), .outputGoodFlag(pins[0]),
    .dummyLoadActive(pins[1]), .initDone(pins[2]), .nvmAccessError(pins[3]), .remoteOn(remoteOn),
    .savedOnOff(1'b0), .outputVoltageReading(vout), .rxByte(rxByte), .rxValid(rxValid),
    .rxFrameEnd(rxFrameEnd), .txReady(txReady), .txByte(txByte), .txValid(txValid),
    .outputEnable(outputEnable), .outputOnCommand(outputOnCommand),
    .serialControlSelect(serialControlSelect), .nvmWritePolicy(nvmWritePolicy),
    .nvmStoreDisable(nvmStoreDisable), .nvmStorePulse(nvmStorePulse));

  psm_master_model psm_master_model_inst (
    .clk_sys(clk_sys), .rxByte(rxByte), .rxValid(rxValid), .rxFrameEnd(rxFrameEnd), .txReady(txReady));

  // ************************************************************
  // comparison and closing
  // ************************************************************
  task automatic cmpb(input logic [7:0] e, input logic [7:0] a);
    checks_done++;
    if (a !== e) begin
      err_count++;
      $display("[FAIL] t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask

  task automatic cmpp(input logic [15:0] e, input logic [15:0] a);
    checks_done++;
    if (a !== e) begin
      err_count++;
      $display("[FAIL] t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask

  task automatic end_sim();
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ************************************************************
  // answer monitor and store pulse count
  // ************************************************************
  always @(posedge clk_sys) begin
    if (rst_n && txValid === 1'b1 && txReady === 1'b1) begin
      if (q.size() == 0) cmpb(8'hxx, txByte);
      else cmpb(q.pop_front(), txByte);
    end
    if (nvmStorePulse === 1'b1) pulses++;
  end

  // ************************************************************
  // frame helpers
  // ************************************************************
  // ans holds n leading bytes; their check sum is appended low byte first
  task automatic run(input logic [47:0] h, input logic bad, input logic [63:0] ans, input int n);
    logic [15:0] c;
    c = psm_master_model_inst.crc16(ans, n);
    for (int i = 0; i < n; i++) q.push_back(ans[63-8*i -: 8]);
    if (n > 0) q.push_back(c[7:0]);
    if (n > 0) q.push_back(c[15:8]);
    psm_master_model_inst.send(h, bad);
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 400 && (q.size() != 0 || txValid !== 1'b0); i++) @(posedge clk_sys);
    cmpp(16'h0000, 16'(q.size()));
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    run({8'h80, FC_WRITE_ONE, a, v}, 1'b0, {8'h80, FC_WRITE_ONE, a, v, 16'h0000}, 6);
  endtask

  task automatic rd(input logic [7:0] fc, input logic [15:0] a, input logic [7:0] n, input logic [31:0] e);
    run({8'h80, fc, a, 8'h00, n}, 1'b0, {8'h80, fc, n << 1, e, 8'h00}, 3 + 2 * int'(n));
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (7) @(posedge clk_sys);
    cmpp(16'h0001, {15'h0000, outputOnCommand});
    cmpp(16'h0000, {13'h0000, serialControlSelect, nvmWritePolicy});
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    cmpp(16'h0001, {15'h0000, outputEnable});
    // analog side off: with serial control clear the output must follow it
    remoteOn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cmpp(16'h0000, {15'h0000, outputEnable});
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      pins <= 4'($random(seed));
      vout <= 16'($random(seed));
      repeat (4) @(posedge clk_sys);
      rd(FC_READ_HOLD, ADDR_STATUS, 8'h02, {9'h000, pins[3:1], 2'b00, pins[0], 1'b0, setup});
      rd(FC_READ_INPUT, ADDR_VOUT, 8'h01, {vout, 16'h0000});
    end
    // reserved codes keep their old field, unassigned bits stay clear
    wr(ADDR_SETUP, 16'hffff);
    setup = 16'h0403;
    rd(FC_READ_HOLD, ADDR_SETUP, 8'h01, {setup, 16'h0000});
    cmpp(16'h0001, {15'h0000, serialControlSelect});
    cmpp(16'h0001, {15'h0000, nvmStoreDisable});
    base = pulses;
    wr(ADDR_ON_OFF, CMD_OFF);
    repeat (70) @(posedge clk_sys);
    cmpp(16'h0000, {15'h0000, outputOnCommand});
    cmpp(16'h0000, {15'h0000, outputEnable});
    cmpp(16'h0000, 16'(pulses - base));
    for (int p = 0; p < 3; p++) begin
      wr(ADDR_SETUP, 16'h0003 | 16'(p << 8));
      repeat (70) @(posedge clk_sys);
      cmpp(16'(p), {14'h0000, nvmWritePolicy});
      base = pulses;
      wr(ADDR_ON_OFF, CMD_ON);
      repeat (70) @(posedge clk_sys);
      cmpp(16'h0001, 16'(pulses - base));
      cmpp(16'h0001, {15'h0000, outputEnable});
    end
    run({8'h80, FC_READ_HOLD, ADDR_STATUS, 16'h0001}, 1'b1, 64'h0, 0);
    run({8'h81, FC_READ_HOLD, ADDR_STATUS, 16'h0001}, 1'b0, 64'h0, 0);
    run({8'h80, 8'h05, ADDR_ON_OFF, 16'h0001}, 1'b0, 64'h0, 0);
    run({8'h80, FC_READ_HOLD, ADDR_STATUS, 16'h0000}, 1'b0, 64'h0, 0);
    rd(FC_READ_INPUT, ADDR_VOUT, 8'h01, {vout, 16'h0000});
    end_sim();
  end

  initial begin
    repeat (50000) @(posedge clk_sys);
    err_count++;
    end_sim();
  end
endmodule
